// *** calibration_coefficient_store.sv ***
// Calibration coefficient word store with host port and coefficient outputs
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "coef_store_consts.svh"
module calibration_coefficient_store
   import coef_store_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 arst_n,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire logic [`WORD_W-1:0]   wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output logic      [`WORD_W-1:0]   rdata,
   output coef_t                     sensor_offset_coef,
   output coef_t                     sensor_gain_coef,
   output coef_t                     gain_temp_coef,
   output coef_t                     offset_temp_coef,
   output coef_t                     offset_temp_second_order_coef,
   output coef_t                     gain_temp_second_order_coef,
   output coef_t                     readout_second_order_coef,
   output coef_t                     temperature_offset_coef,
   output coef_t                     temperature_gain_coef,
   output coef_t                     temperature_second_order_coef
);
   coef_words_if words ();
   word_t low_q  [`NUM_COEF];
   word_t high_q [`NUM_HIGH];
   coef_t coef   [`NUM_COEF];

   // Address classification, used by the read path and the unmapped-read check
   function automatic logic is_low(input logic [`ADDR_W-1:0] a);
      return (a >= `LOW_BASE) && (a <= `LOW_LAST);
   endfunction
   function automatic logic is_high(input logic [`ADDR_W-1:0] a);
      return (a >= `HIGH_BASE) && (a <= `HIGH_LAST);
   endfunction

   // Low words; writes outside the map are dropped
   for (genvar i = 0; i < `NUM_COEF; i++) begin : g_low
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            low_q[i] <= `WORD_RESET;
         end else if (wr_stb && addr == `ADDR_W'(`LOW_BASE + i)) begin
            low_q[i] <= wdata;
         end
      end
   end

   // Packed high-byte pair words
   for (genvar j = 0; j < `NUM_HIGH; j++) begin : g_high
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            high_q[j] <= `WORD_RESET;
         end else if (wr_stb && addr == `ADDR_W'(`HIGH_BASE + j)) begin
            high_q[j] <= wdata;
         end
      end
   end

   assign words.low_word  = low_q;
   assign words.high_word = high_q;

   coef_assemble u_asm (
      .words (words.build),
      .coef  (coef)
   );

   // Read data valid only the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= `WORD_RESET;
      end else if (rd_stb && is_low(addr)) begin
         rdata <= low_q[4'(addr - `LOW_BASE)];
      end else if (rd_stb && is_high(addr)) begin
         rdata <= high_q[3'(addr - `HIGH_BASE)];
      end else begin
         rdata <= `WORD_RESET;
      end
   end

   // Coefficient outputs, signed for the correction math
   assign sensor_offset_coef            = coef[0];
   assign sensor_gain_coef              = coef[1];
   assign gain_temp_coef                = coef[2];
   assign offset_temp_coef              = coef[3];
   assign offset_temp_second_order_coef = coef[4];
   assign gain_temp_second_order_coef   = coef[5];
   assign readout_second_order_coef     = coef[6];
   assign temperature_offset_coef       = coef[7];
   assign temperature_gain_coef         = coef[8];
   assign temperature_second_order_coef = coef[9];

   // Checks on coefficient assembly, sign and readback, one group per coefficient
   // Readback is checked against the coefficient outputs, so a wrong pairing shows twice

   // Sensor offset: low word and upper byte of the first pair word
   AST_OFFSET: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_SENS_OFF |=> sensor_offset_coef[15:0] == $past(wdata))
      else $error("offset low word not applied");
   AST_OFFSET_HI: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 |=> sensor_offset_coef[23:16] == $past(wdata[15:8]))
      else $error("offset high byte wrong");
   AST_SIGN: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 && wdata[15] |=> sensor_offset_coef < 0)
      else $error("offset sign not negative");
   AST_OFFSET_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 && !wdata[15] |=> sensor_offset_coef >= 0)
      else $error("offset sign not positive");
   AST_OFFSET_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_SENS_OFF |=> rdata == $past(sensor_offset_coef[15:0]))
      else $error("offset low readback wrong");
   AST_PAIR0_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_PAIR0 |=> rdata == $past({sensor_offset_coef[23:16], sensor_gain_coef[23:16]}))
      else $error("first pair readback wrong");

   // Sensor gain: low word and lower byte of the first pair word
   AST_GAIN_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_SENS_GAIN |=> sensor_gain_coef[15:0] == $past(wdata))
      else $error("gain low word wrong");
   AST_GAIN_HI: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 |=> sensor_gain_coef[23:16] == $past(wdata[7:0]))
      else $error("gain high byte wrong");
   AST_GAIN_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 && wdata[7] |=> sensor_gain_coef < 0)
      else $error("gain sign not negative");
   AST_GAIN_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR0 && !wdata[7] |=> sensor_gain_coef >= 0)
      else $error("gain sign not positive");
   AST_GAIN_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_SENS_GAIN |=> rdata == $past(sensor_gain_coef[15:0]))
      else $error("gain low readback wrong");

   // Gain temperature term: low word and upper byte of the second pair word
   AST_GTEMP_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_GTEMP |=> gain_temp_coef[15:0] == $past(wdata))
      else $error("gain temp low word wrong");
   AST_GTEMP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 |=> gain_temp_coef[23:16] == $past(wdata[15:8]))
      else $error("gain temp high byte wrong");
   AST_GTEMP_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 && wdata[15] |=> gain_temp_coef < 0)
      else $error("gain temp sign not negative");
   AST_GTEMP_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 && !wdata[15] |=> gain_temp_coef >= 0)
      else $error("gain temp sign not positive");
   AST_READBACK: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_GTEMP |=> rdata == $past(gain_temp_coef[15:0]))
      else $error("readback mismatch");
   AST_PAIR1_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_PAIR1 |=> rdata == $past({gain_temp_coef[23:16], offset_temp_coef[23:16]}))
      else $error("second pair readback wrong");

   // Offset temperature term: low word and lower byte of the second pair word
   AST_OTEMP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_OTEMP |=> offset_temp_coef[15:0] == $past(wdata))
      else $error("offset temp low word wrong");
   AST_OTEMP_HI: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 |=> offset_temp_coef[23:16] == $past(wdata[7:0]))
      else $error("offset temp high byte wrong");
   AST_OTEMP_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 && wdata[7] |=> offset_temp_coef < 0)
      else $error("offset temp sign not negative");
   AST_OTEMP_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR1 && !wdata[7] |=> offset_temp_coef >= 0)
      else $error("offset temp sign not positive");
   AST_OTEMP_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_OTEMP |=> rdata == $past(offset_temp_coef[15:0]))
      else $error("offset temp readback wrong");

   // Offset second-order term: low word and upper byte of the third pair word
   AST_OSOT_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_OSOT |=> offset_temp_second_order_coef[15:0] == $past(wdata))
      else $error("offset second order low wrong");
   AST_OSOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 |=> offset_temp_second_order_coef[23:16] == $past(wdata[15:8]))
      else $error("offset second order high wrong");
   AST_OSOT_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 && wdata[15] |=> offset_temp_second_order_coef < 0)
      else $error("offset second order sign not negative");
   AST_OSOT_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 && !wdata[15] |=> offset_temp_second_order_coef >= 0)
      else $error("offset second order sign not positive");
   AST_OSOT_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_OSOT |=> rdata == $past(offset_temp_second_order_coef[15:0]))
      else $error("offset second order readback wrong");
   AST_PAIR2_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_PAIR2 |=> rdata == $past({offset_temp_second_order_coef[23:16],
                                                       gain_temp_second_order_coef[23:16]}))
      else $error("third pair readback wrong");

   // Gain second-order term: low word and lower byte of the third pair word
   AST_GSOT_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_GSOT |=> gain_temp_second_order_coef[15:0] == $past(wdata))
      else $error("gain second order low wrong");
   AST_GSOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 |=> gain_temp_second_order_coef[23:16] == $past(wdata[7:0]))
      else $error("gain second order high wrong");
   AST_GSOT_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 && wdata[7] |=> gain_temp_second_order_coef < 0)
      else $error("gain second order sign not negative");
   AST_GSOT_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR2 && !wdata[7] |=> gain_temp_second_order_coef >= 0)
      else $error("gain second order sign not positive");
   AST_GSOT_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_GSOT |=> rdata == $past(gain_temp_second_order_coef[15:0]))
      else $error("gain second order readback wrong");

   // Readout second-order term: low word and upper byte of the fourth pair word
   AST_RSOT_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_RSOT |=> readout_second_order_coef[15:0] == $past(wdata))
      else $error("readout second order low wrong");
   AST_RSOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 |=> readout_second_order_coef[23:16] == $past(wdata[15:8]))
      else $error("readout second order high wrong");
   AST_RSOT_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 && wdata[15] |=> readout_second_order_coef < 0)
      else $error("readout second order sign not negative");
   AST_RSOT_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 && !wdata[15] |=> readout_second_order_coef >= 0)
      else $error("readout second order sign not positive");
   AST_RSOT_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_RSOT |=> rdata == $past(readout_second_order_coef[15:0]))
      else $error("readout second order readback wrong");
   AST_PAIR3_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_PAIR3 |=> rdata == $past({readout_second_order_coef[23:16],
                                                       temperature_offset_coef[23:16]}))
      else $error("fourth pair readback wrong");

   // Temperature offset: low word and lower byte of the fourth pair word
   AST_TOFF_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_TOFF |=> temperature_offset_coef[15:0] == $past(wdata))
      else $error("temperature offset low wrong");
   AST_TOFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 |=> temperature_offset_coef[23:16] == $past(wdata[7:0]))
      else $error("temperature offset high wrong");
   AST_TOFF_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 && wdata[7] |=> temperature_offset_coef < 0)
      else $error("temperature offset sign not negative");
   AST_TOFF_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR3 && !wdata[7] |=> temperature_offset_coef >= 0)
      else $error("temperature offset sign not positive");
   AST_TOFF_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_TOFF |=> rdata == $past(temperature_offset_coef[15:0]))
      else $error("temperature offset readback wrong");

   // Temperature gain: low word and upper byte of the last pair word
   AST_TGAIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_TGAIN |=> temperature_gain_coef[15:0] == $past(wdata))
      else $error("temperature gain low wrong");
   AST_TGAIN_HI: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 |=> temperature_gain_coef[23:16] == $past(wdata[15:8]))
      else $error("temperature gain high wrong");
   AST_TGAIN_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 && wdata[15] |=> temperature_gain_coef < 0)
      else $error("temperature gain sign not negative");
   AST_TGAIN_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 && !wdata[15] |=> temperature_gain_coef >= 0)
      else $error("temperature gain sign not positive");
   AST_TGAIN_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_TGAIN |=> rdata == $past(temperature_gain_coef[15:0]))
      else $error("temperature gain readback wrong");
   AST_PAIR4_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_PAIR4 |=> rdata == $past({temperature_gain_coef[23:16],
                                                       temperature_second_order_coef[23:16]}))
      else $error("last pair readback wrong");

   // Temperature second-order term: low word and lower byte of the last pair word
   AST_TSOT_LO: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_TSOT |=> temperature_second_order_coef[15:0] == $past(wdata))
      else $error("temperature second order low wrong");
   AST_TSOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 |=> temperature_second_order_coef[23:16] == $past(wdata[7:0]))
      else $error("temperature second order high wrong");
   AST_TSOT_NEG: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 && wdata[7] |=> temperature_second_order_coef < 0)
      else $error("temperature second order sign not negative");
   AST_TSOT_POS: assert property (@(posedge ref_clk) disable iff (!arst_n)
      wr_stb && addr == `ADR_PAIR4 && !wdata[7] |=> temperature_second_order_coef >= 0)
      else $error("temperature second order sign not positive");
   AST_TSOT_RB: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && addr == `ADR_TSOT |=> rdata == $past(temperature_second_order_coef[15:0]))
      else $error("temperature second order readback wrong");

   // Read port: data stand one cycle only, unmapped reads give zero, reset zeroes rdata and the first and last coefficients
   AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !rd_stb |=> rdata == `WORD_RESET)
      else $error("read data not cleared after strobe");
   AST_RD_UNMAP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rd_stb && !is_low(addr) && !is_high(addr) |=> rdata == `WORD_RESET)
      else $error("unmapped read not zero");
   AST_RST_ZERO: assert property (@(posedge ref_clk)
      !arst_n |-> rdata == `WORD_RESET && sensor_offset_coef == 0 && temperature_second_order_coef == 0)
      else $error("reset values not zero");

   // Main scenarios worth seeing in a run
   COV_WRITE_HIGH: cover property (@(posedge ref_clk) disable iff (!arst_n) wr_stb && addr == `ADR_PAIR0);
   COV_READ_LOW: cover property (@(posedge ref_clk) disable iff (!arst_n) rd_stb && addr == `ADR_SENS_OFF);
   COV_NEG_COEF: cover property (@(posedge ref_clk) disable iff (!arst_n) temperature_gain_coef < 0);
   COV_WR_THEN_RD: cover property (@(posedge ref_clk) disable iff (!arst_n) wr_stb ##2 rd_stb);
endmodule

// *** coef_store_consts.svh ***
// Register offsets, widths and reset values of the calibration coefficient store
`ifndef COEF_STORE_CONSTS_SVH
`define COEF_STORE_CONSTS_SVH
`define ADDR_W            5
`define WORD_W            16
`define COEF_W            24
`define NUM_COEF          10
`define LOW_BASE          5'h03
`define LOW_LAST          5'h0c
`define HIGH_BASE         5'h0d
`define HIGH_LAST         5'h11
`define NUM_HIGH          5
`define ADR_SENS_OFF      5'h03
`define ADR_SENS_GAIN     5'h04
`define ADR_GTEMP         5'h05
`define ADR_OTEMP         5'h06
`define ADR_OSOT          5'h07
`define ADR_GSOT          5'h08
`define ADR_RSOT          5'h09
`define ADR_TOFF          5'h0a
`define ADR_TGAIN         5'h0b
`define ADR_TSOT          5'h0c
`define ADR_PAIR0         5'h0d
`define ADR_PAIR1         5'h0e
`define ADR_PAIR2         5'h0f
`define ADR_PAIR3         5'h10
`define ADR_PAIR4         5'h11
`define WORD_RESET        16'h0000
`define HIGH_UPPER_MSB    15
`define HIGH_UPPER_LSB    8
`define HIGH_LOWER_MSB    7
`define HIGH_LOWER_LSB    0
`define COEF_SIGN_BIT     23
`endif

// *** coef_store_pkg.sv ***
// Types shared by the calibration coefficient store
`include "coef_store_consts.svh"
package coef_store_pkg;
   typedef logic [`WORD_W-1:0] word_t;
   typedef logic signed [`COEF_W-1:0] coef_t;
   typedef enum logic [9:0] {
      sensor_offset = 10'h001, sensor_gain = 10'h002, gain_temp = 10'h004, offset_temp = 10'h008,
      offset_temp_second_order = 10'h010, gain_temp_second_order = 10'h020,
      readout_second_order = 10'h040, temperature_offset = 10'h080, temperature_gain = 10'h100,
      temperature_second_order = 10'h200
   } coef_sel_t;
endpackage

// *** coef_words_if.sv ***
// Raw stored words passed from the register file to the assembler
`timescale 1ns/1ns
`include "coef_store_consts.svh"
interface coef_words_if;
   import coef_store_pkg::*;
   word_t low_word  [`NUM_COEF];
   word_t high_word [`NUM_HIGH];
   modport store (output low_word, output high_word);
   modport build (input low_word, input high_word);
endinterface

// *** coef_assemble.sv ***
// Joins low words and packed high bytes into signed 24-bit coefficients
`timescale 1ns/1ns
`include "coef_store_consts.svh"
module coef_assemble
   import coef_store_pkg::*;
(
   coef_words_if.build    words,
   output coef_t          coef [`NUM_COEF]
);
   // Even coefficients take the upper byte of their pair word, odd ones the lower byte
   for (genvar i = 0; i < `NUM_COEF; i++) begin : g_coef
      if (i % 2 == 0) begin : g_up
         assign coef[i] = {words.high_word[i/2][`HIGH_UPPER_MSB:`HIGH_UPPER_LSB], words.low_word[i]};
      end else begin : g_lo
         assign coef[i] = {words.high_word[i/2][`HIGH_LOWER_MSB:`HIGH_LOWER_LSB], words.low_word[i]};
      end
   end
endmodule

// *** calibration_coefficient_store_tb.sv ***
// Self-checking testbench for the calibration coefficient store
`timescale 1ns/1ns
`include "coef_store_consts.svh"
module calibration_coefficient_store_tb
   import coef_store_pkg::*;
;
   logic                 ref_clk;
   logic                 arst_n;
   logic [`ADDR_W-1:0]   addr;
   logic [`WORD_W-1:0]   wdata;
   logic                 wr_stb;
   logic                 rd_stb;
   logic [`WORD_W-1:0]   rdata;
   coef_t                seen_c [`NUM_COEF];
   word_t                mem [32];
   int                   err_total;
   int                   num_checks;
   word_t                corner [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};

   calibration_coefficient_store u_calibration_coefficient_store (
      .ref_clk                       (ref_clk),
      .arst_n                        (arst_n),
      .addr                          (addr),
      .wdata                         (wdata),
      .wr_stb                        (wr_stb),
      .rd_stb                        (rd_stb),
      .rdata                         (rdata),
      .sensor_offset_coef            (seen_c[0]),
      .sensor_gain_coef              (seen_c[1]),
      .gain_temp_coef                (seen_c[2]),
      .offset_temp_coef              (seen_c[3]),
      .offset_temp_second_order_coef (seen_c[4]),
      .gain_temp_second_order_coef   (seen_c[5]),
      .readout_second_order_coef     (seen_c[6]),
      .temperature_offset_coef       (seen_c[7]),
      .temperature_gain_coef         (seen_c[8]),
      .temperature_second_order_coef (seen_c[9])
   );

   // Free-running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Upper byte of a packed word goes to the even coefficient of the pair
   function automatic logic [23:0] exp_coef(input int i);
      word_t h;
      h = mem[`HIGH_BASE + i / 2];
      exp_coef = {(i % 2 == 0) ? h[15:8] : h[7:0], mem[`LOW_BASE + i]};
   endfunction

   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic chk_coefs();
      for (int i = 0; i < `NUM_COEF; i++) begin
         chk($sformatf("coef%0d", i), seen_c[i], exp_coef(i));
      end
   endtask

   // Unmapped writes leave the model untouched, as the store must
   task automatic wr(input logic [4:0] a, input word_t d);
      @(posedge ref_clk);
      wr_stb <= 1'b1;
      addr   <= a;
      wdata  <= d;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      if (a >= `LOW_BASE && a <= `HIGH_LAST) mem[a] = d;
      #1 chk_coefs();
   endtask

   // Read data stand one cycle only, then fall back to zero
   task automatic rd(input logic [4:0] a);
      @(posedge ref_clk);
      rd_stb <= 1'b1;
      addr   <= a;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 chk($sformatf("rdata%0h", a), {8'h00, rdata}, {8'h00, mem[a]});
      @(posedge ref_clk);
      #1 chk("rdata_idle", {8'h00, rdata}, 24'h000000);
   endtask

   // Reset for three cycles and clear the model with it
   task automatic do_reset();
      arst_n <= 1'b0;
      foreach (mem[k]) mem[k] = `WORD_RESET;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      #1 chk_coefs();
      for (int k = 0; k < 32; k++) rd(k[4:0]);
   endtask

   task automatic end_sim();
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the expected run of under two thousand cycles
   initial begin
      #200000;
      err_total++;
      end_sim();
   end

   // Main sequence: reset values, corner and random traffic, unmapped accesses, final reset
   initial begin
      arst_n = 1'b0;
      addr   = '0;
      wdata  = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      err_total  = 0;
      num_checks = 0;
      void'($urandom(71));
      do_reset();
      for (int k = `LOW_BASE; k <= `HIGH_LAST; k++) wr(k[4:0], corner[k % 4]);
      for (int n = 0; n < 300; n++) begin
         wr(5'($urandom), (n % 5 == 0) ? corner[$urandom % 4] : 16'($urandom));
         rd(5'($urandom));
      end
      wr(5'h12, 16'hffff);
      wr(5'h00, 16'h8000);
      rd(5'h00);
      do_reset();
      end_sim();
   end
endmodule
